// ### rtl/rlc_pkg.sv
package rlc_pkg;
  // Register map (index and byte address coincide on this plain port)
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_MODE = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam int ADDR_W = 2;

  // Control register layout and reset value
  localparam int BIT_POWER = 7;
  localparam int BIT_PIN_DRIVE = 6;
  localparam int BIT_RANGE = 5;
  localparam int BIT_SOURCE = 4;
  localparam int TAP_MSB = 3;
  localparam int TAP_LSB = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Comparator mode field and the setting that routes the ladder inward
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_FOUR_MUX = 3'h6;

  // Port bits touched by the pin drive
  localparam int PORT_BIT_SHARED = 0;
  localparam int PORT_BIT_NEG_REF = 2;

  // Level numerator: level = num / 96 of the supply span
  localparam int LEVEL_W = 7;
  localparam logic [6:0] QUARTER_OFFSET = 7'h18;
endpackage : rlc_pkg

// ### rtl/rlc_ladder_control.sv
// Contract
// - Bit 7 set powers ladder on; clear powers it down.
// - Bit 6 set routes level to shared analog pin; clear detaches it.
// - Bit 5 picks range: 1 is zero-based /24, 0 is quarter-based /32.
// - Bit 4 picks supply: 1 external reference pins, 0 device rails.
// - Low four bits hold tap 0..15 choosing one of sixteen levels.
// - Level is tap/24 of span, or span/4 plus tap/32 of span.
// - Pin drive overrides port direction bit 0 of the shared pin.
// - Reset clears power, pin drive, range and tap bits.
// - Wake from sleep leaves the control register unchanged.
// - Ladder works independently of comparator mode.
// - Ladder feeds comparator positive inputs only in four-input mux mode.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module rlc_ladder_control (
  input wire logic clk_in, // System clock, 100 MHz
  input wire logic rst_in, // Synchronous device reset, active high
  input wire logic wake_in, // Wake from sleep pulse, no effect on state
  input wire logic [rlc_pkg::ADDR_W-1:0] addr_in, // Register address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic [7:0] port_dir_in, // Port A direction bits, 1 = input
  output logic [7:0] rdata_out, // Read data, cycle after read strobe
  output logic power_on_out, // Ladder powered
  output logic pin_drive_out, // Level routed to shared analog pin
  output logic range_select_out, // Ladder range
  output logic source_select_out, // Ladder supply source
  output logic [3:0] tap_value_out, // Ladder tap
  output logic [rlc_pkg::LEVEL_W-1:0] level_num_out, // Level in 96ths of span
  output logic shared_pin_dir_out, // Effective direction of shared pin, 1 = input
  output logic neg_ref_conflict_out, // Pin drive on while negative ref pin is output
  output logic cmp_ref_internal_out // Ladder feeds comparator positive inputs
);

  // Ladder level, counted in 96ths of the supply span
  typedef logic [rlc_pkg::LEVEL_W-1:0] rlc_level_t;

  // Stored control byte and comparator mode mirror, with their pending values
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [rlc_pkg::MODE_W-1:0] mode_reg;
  logic [rlc_pkg::MODE_W-1:0] mode_next;

  // Strobe decode results
  logic control_write;
  logic mode_write;

  // Pending values for the registered outputs
  wire logic [3:0] tap_pending;
  rlc_level_t level_next;
  logic shared_dir_next;
  logic conflict_next;
  logic route_next;
  logic [7:0] read_next;

  // Write decode, shared by the control register and the mode mirror
  function automatic logic write_hits(
    input logic wr,
    input logic [rlc_pkg::ADDR_W-1:0] addr,
    input logic [rlc_pkg::ADDR_W-1:0] target
  );
    write_hits = wr && (addr == target);
  endfunction : write_hits

  // One control bit of a stored or pending byte
  function automatic logic bit_of(
    input logic [7:0] c,
    input int pos
  );
    bit_of = c[pos];
  endfunction : bit_of

  // Tap field of a stored or pending byte
  function automatic logic [3:0] tap_of(
    input logic [7:0] c
  );
    tap_of = c[rlc_pkg::TAP_MSB:rlc_pkg::TAP_LSB];
  endfunction : tap_of

  // Level in 96ths: tap*4 for the /24 range, quarter plus tap*3 for /32
  // Working in 96ths keeps both ranges exact integers with no divider
  function automatic rlc_level_t level_of(
    input logic [7:0] c
  );
    rlc_level_t tap;
    tap = rlc_level_t'(tap_of(c));
    if (bit_of(c, rlc_pkg::BIT_RANGE)) begin
      level_of = tap << 2;
    end else begin
      level_of = rlc_pkg::QUARTER_OFFSET + (tap << 1) + tap;
    end
  endfunction : level_of

  // Status byte packing, low bits only
  function automatic logic [7:0] status_of(
    input logic route,
    input logic conflict,
    input logic shared_dir
  );
    status_of = 8'({route, conflict, shared_dir});
  endfunction : status_of

  // Mode decode for the inward route
  function automatic logic is_four_mux(
    input logic [rlc_pkg::MODE_W-1:0] mode
  );
    is_four_mux = (mode == rlc_pkg::MODE_FOUR_MUX);
  endfunction : is_four_mux

  // Strobe decode; wake_in is deliberately unused so sleep exits keep state
  always_comb begin
    control_write = write_hits(wr_in, addr_in, rlc_pkg::ADDR_CONTROL);
    mode_write = write_hits(wr_in, addr_in, rlc_pkg::ADDR_MODE);
  end

  // Pending control byte: a whole-byte write replaces it, nothing else does
  always_comb begin
    control_next = control_reg;
    if (control_write) begin
      control_next = wdata_in;
    end
  end

  // Control register; only device reset clears it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      control_reg <= rlc_pkg::CONTROL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  // Pending comparator mode
  always_comb begin
    mode_next = mode_reg;
    if (mode_write) begin
      mode_next = wdata_in[rlc_pkg::MODE_W-1:0];
    end
  end

  // Comparator mode mirror; it steers only the inward route, never the ladder
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg <= rlc_pkg::MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Tap bits picked out one by one from the pending byte
  for (genvar i = 0; i < 4; i++) begin : g_tap
    assign tap_pending[i] = control_next[rlc_pkg::TAP_LSB + i];
  end

  // Power output; registered from the pending byte so it tracks the write edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_on_out <= rlc_pkg::CONTROL_RESET[rlc_pkg::BIT_POWER];
    end else begin
      power_on_out <= bit_of(control_next, rlc_pkg::BIT_POWER);
    end
  end

  // Pin drive output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_drive_out <= rlc_pkg::CONTROL_RESET[rlc_pkg::BIT_PIN_DRIVE];
    end else begin
      pin_drive_out <= bit_of(control_next, rlc_pkg::BIT_PIN_DRIVE);
    end
  end

  // Range output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      range_select_out <= rlc_pkg::CONTROL_RESET[rlc_pkg::BIT_RANGE];
    end else begin
      range_select_out <= bit_of(control_next, rlc_pkg::BIT_RANGE);
    end
  end

  // Supply source output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      source_select_out <= rlc_pkg::CONTROL_RESET[rlc_pkg::BIT_SOURCE];
    end else begin
      source_select_out <= bit_of(control_next, rlc_pkg::BIT_SOURCE);
    end
  end

  // Tap output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tap_value_out <= rlc_pkg::CONTROL_RESET[rlc_pkg::TAP_MSB:rlc_pkg::TAP_LSB];
    end else begin
      tap_value_out <= tap_pending;
    end
  end

  // Pending level
  always_comb begin
    level_next = level_of(control_next);
  end

  // Level output; the reset value is the quarter-span start of the /32 range
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_num_out <= rlc_pkg::QUARTER_OFFSET;
    end else begin
      level_num_out <= level_next;
    end
  end

  // Pin ownership: drive wins over the direction bit of the shared pin
  always_comb begin
    shared_dir_next = port_dir_in[rlc_pkg::PORT_BIT_SHARED] &
                      ~bit_of(control_next, rlc_pkg::BIT_PIN_DRIVE);
  end

  // Effective shared pin direction; port bits are seen one cycle late
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shared_pin_dir_out <= 1'b1;
    end else begin
      shared_pin_dir_out <= shared_dir_next;
    end
  end

  // Missing input setup on the negative reference pin while driving
  always_comb begin
    conflict_next = bit_of(control_next, rlc_pkg::BIT_PIN_DRIVE) &
                    ~port_dir_in[rlc_pkg::PORT_BIT_NEG_REF];
  end

  // Conflict flag; only reported, software has to fix the direction itself
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      neg_ref_conflict_out <= 1'b0;
    end else begin
      neg_ref_conflict_out <= conflict_next;
    end
  end

  // Inward route decode from the pending mode
  always_comb begin
    route_next = is_four_mux(mode_next);
  end

  // Inward route to both comparators only in four-input mux mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmp_ref_internal_out <= 1'b0;
    end else begin
      cmp_ref_internal_out <= route_next;
    end
  end

  // Read mux; idle cycles read zero so stale data never lingers on the bus
  always_comb begin
    read_next = '0;
    if (rd_in) begin
      unique case (addr_in)
        rlc_pkg::ADDR_CONTROL: begin
          read_next = control_reg;
        end
        rlc_pkg::ADDR_MODE: begin
          read_next = 8'(mode_reg);
        end
        rlc_pkg::ADDR_STATUS: begin
          read_next = status_of(cmp_ref_internal_out, neg_ref_conflict_out,
                                shared_pin_dir_out);
        end
        default: begin
          read_next = '0;
        end
      endcase
    end
  end

  // Read data register; it stands only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= read_next;
    end
  end

endmodule : rlc_ladder_control

// ### dv/rlc_ladder_monitor.sv
`timescale 1ns/1ps
module rlc_ladder_monitor (
  input wire logic clk_in, rst_in, wr_in, rd_in, // Clock, reset, strobes
  input wire logic [rlc_pkg::ADDR_W-1:0] addr_in, // Address
  input wire logic [7:0] wdata_in, port_dir_in, rdata_out, // Bus, port
  input wire logic power_on_out, pin_drive_out, range_select_out, source_select_out, // Ctl
  input wire logic [3:0] tap_value_out, // Tap
  input wire logic [rlc_pkg::LEVEL_W-1:0] level_num_out, // Level
  input wire logic shared_pin_dir_out, neg_ref_conflict_out, cmp_ref_internal_out // Status
);
  // Split control outputs rebuilt as one byte for compact checks
  wire logic [7:0] ctl = {power_on_out, pin_drive_out, range_select_out, source_select_out,
    tap_value_out};
  wire logic wc = wr_in && addr_in == rlc_pkg::ADDR_CONTROL;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_write_loads: assert property (wc |=> ctl == $past(wdata_in))
    else $error("control write not taken");
  a_ctl_holds: assert property (!wc |=> $stable(ctl))
    else $error("control changed without write");
  a_level_math: assert property (level_num_out == (range_select_out ?
    {1'b0, tap_value_out, 2'b00} : 7'h18 + 7'(tap_value_out) * 7'h3)) else $error("bad level");
  a_reset_clears: assert property (disable iff (1'b0) rst_in |=> ctl == 8'h00)
    else $error("reset left control set");
  a_read_back: assert property (rd_in && addr_in == 2'h0 |=> rdata_out == ctl)
    else $error("read data wrong");
  // Port-derived flags lag one cycle, so only judge them while the drive bit holds still
  a_pin_override: assert property (!$past(rst_in) && $stable(pin_drive_out) |->
    shared_pin_dir_out == ($past(port_dir_in[0]) & !pin_drive_out)) else $error("pin dir");
  a_neg_conflict: assert property (!$past(rst_in) && $stable(pin_drive_out) |->
    neg_ref_conflict_out == (pin_drive_out & !$past(port_dir_in[2]))) else $error("conflict");
  a_mux_route: assert property (wr_in && addr_in == rlc_pkg::ADDR_MODE |=>
    cmp_ref_internal_out == ($past(wdata_in[2:0]) == rlc_pkg::MODE_FOUR_MUX))
    else $error("comparator route wrong");
  c_drive: cover property (wc && wdata_in[6]);
  c_read: cover property (rd_in);
  c_route: cover property (cmp_ref_internal_out);
endmodule : rlc_ladder_monitor
bind rlc_ladder_control rlc_ladder_monitor u_mon (.*);

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %0t %h %h", $time, (g), (e)); end end
module tb_top;
  logic clk_in = 0, rst_in = 1, wake_in = 0, wr_in = 0, rd_in = 0;
  logic [1:0] addr_in = 0;
  logic [7:0] wdata_in = 0, port_dir_in = 8'hff, rdata_out;
  logic power_on_out, pin_drive_out, range_select_out, source_select_out;
  logic [3:0] tap_value_out;
  logic [6:0] level_num_out;
  logic shared_pin_dir_out, neg_ref_conflict_out, cmp_ref_internal_out;
  int err_count = 0, comparisons = 0;
  wire logic [7:0] ctl = {power_on_out, pin_drive_out, range_select_out, source_select_out,
    tap_value_out};
  rlc_ladder_control uut (.*);
  always #5 clk_in = ~clk_in;
  // Strobes last one edge; the trailing #1 lets the taking edge settle before checks
  task automatic op(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {addr_in, wdata_in, wr_in, rd_in} <= {a, d, w, !w};
    @(posedge clk_in);
    {wr_in, rd_in} <= 2'b00;
    #1;
    if (!w) `CHK(rdata_out, d)
  endtask : op
  task automatic t_codes;
    logic [7:0] v[5] = '{8'hc5, 8'h3f, 8'hb0, 8'h20, 8'h1f};
    `CHK({ctl, level_num_out, shared_pin_dir_out}, {8'h00, 7'h18, 1'b1})
    foreach (v[i]) begin
      op(1, 2'h0, v[i]);
      `CHK({ctl, level_num_out}, {v[i], v[i][5] ? 7'(4 * v[i][3:0]) : 7'(24 + 3 * v[i][3:0])})
      op(0, 2'h0, v[i]);
    end
  endtask : t_codes
  // Drive bit set while the negative reference pin is an output must raise the flag
  task automatic t_pin;
    @(posedge clk_in);
    port_dir_in <= 8'h01;
    op(1, 2'h0, 8'h40);
    op(0, 2'h2, 8'h02);
    @(posedge clk_in);
    port_dir_in <= 8'h05;
    #1 `CHK({shared_pin_dir_out, neg_ref_conflict_out}, 2'b01)
    @(posedge clk_in);
    #1 `CHK(neg_ref_conflict_out, 1'b0)
    op(1, 2'h0, 8'h80);
    @(posedge clk_in);
    #1 `CHK(shared_pin_dir_out, 1'b1)
  endtask : t_pin
  task automatic t_mode;
    for (int m = 0; m < 8; m++) begin
      op(1, 2'h1, 8'(m));
      @(posedge clk_in);
      #1 `CHK({cmp_ref_internal_out, ctl}, {m == 6, 8'h80})
      op(0, 2'h1, 8'(m));
    end
    op(1, 2'h3, 8'hff);
    op(0, 2'h3, 8'h00);
    op(1, 2'h0, 8'h1a);
    @(posedge clk_in);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    #1 `CHK(ctl, 8'h1a)
    @(posedge clk_in);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    #1 `CHK(ctl, 8'h00)
  endtask : t_mode
  task automatic test_done;
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Main sequence after the reset hold
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1 t_codes;
    t_pin;
    t_mode;
    test_done;
  end
  // Whole run needs about 93 cycles; the limit is far beyond that
  initial begin
    #20000 err_count++;
    test_done;
  end
endmodule : tb_top
